// *** hw/ucp_cell_port_pair.sv ***
// Byte FIFO and the two cell ports, source and sink, with their link timing
`timescale 1ns/1ps

module ucp_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Drain side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_depth_check
      $error("ucp_fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic push, pop;

   // Full when pointers differ only in the wrap bit
   assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid_o = (wr_ptr != rd_ptr);
   assign out_data_o = mem[rd_ptr[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb
   begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule

module ucp_cell_port_pair
#(
   parameter int FIFO_DEPTH = ucp_pkg::UCP_FIFO_DEPTH
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Static role straps
   input wire ucp_pkg::ucp_src_mode_t src_mode_i,
   input wire ucp_pkg::ucp_snk_mode_t snk_mode_i,
   // Source user side
   input wire logic [ucp_pkg::UCP_BYTE_W-1:0] src_byte_i,
   input wire logic src_byte_valid_i,
   output logic src_byte_ready_o,
   // Sink user side
   output logic [ucp_pkg::UCP_BYTE_W-1:0] snk_byte_o,
   output logic snk_first_o,
   output logic snk_byte_valid_o,
   input wire logic snk_byte_ready_i,
   // Source as ATM layer
   input wire logic src_atm_if_clk_i,
   input wire logic src_atm_phy_full_n_i,
   output logic [ucp_pkg::UCP_BYTE_W-1:0] src_atm_data_out_o,
   output logic src_atm_cell_start_o,
   output logic src_atm_write_enable_n_o,
   // Source as PHY
   input wire logic src_phy_if_clk_i,
   input wire logic src_phy_read_enable_n_i,
   input wire logic src_phy_port_select_n_i,
   output logic [ucp_pkg::UCP_BYTE_W-1:0] src_phy_data_out_o,
   output logic src_phy_cell_start_o,
   output logic src_phy_data_oe_o,
   output logic src_phy_cell_ready_o,
   output logic src_phy_cell_ready_oe_o,
   // Sink as ATM layer
   input wire logic snk_atm_if_clk_i,
   input wire logic [ucp_pkg::UCP_BYTE_W-1:0] snk_atm_data_in_i,
   input wire logic snk_atm_cell_start_i,
   input wire logic snk_atm_phy_empty_n_i,
   output logic snk_atm_read_enable_n_o,
   // Sink as PHY
   input wire logic snk_phy_if_clk_i,
   input wire logic [ucp_pkg::UCP_BYTE_W-1:0] snk_phy_data_in_i,
   input wire logic snk_phy_cell_start_i,
   input wire logic snk_phy_write_enable_n_i,
   output logic snk_phy_space_ready_o
);
   import ucp_pkg::*;

   localparam int BW = UCP_BYTE_W;
   localparam int SYNC_W = 2 * BW - 1;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Roles are static, so the link clocks and sink pins are chosen before the flops to save flops
   logic [SYNC_W-1:0] raw, s1, s2, s3, filt, next_filt;
   logic src_clk_f, src_full_n_f, src_rd_n_f, src_sel_n_f;
   logic snk_clk_f, snk_gate_f, snk_soc_f;
   logic [BW-1:0] snk_data_f;
   logic src_clk_q, snk_clk_q, src_edge, snk_edge;

   assign raw = {(src_mode_i == UCP_SRC_ATM) ? src_atm_if_clk_i : src_phy_if_clk_i,
                 src_atm_phy_full_n_i, src_phy_read_enable_n_i, src_phy_port_select_n_i,
                 (snk_mode_i == UCP_SNK_ATM) ? snk_atm_if_clk_i : snk_phy_if_clk_i,
                 (snk_mode_i == UCP_SNK_ATM) ? snk_atm_phy_empty_n_i : snk_phy_write_enable_n_i,
                 (snk_mode_i == UCP_SNK_ATM) ? snk_atm_cell_start_i : snk_phy_cell_start_i,
                 (snk_mode_i == UCP_SNK_ATM) ? snk_atm_data_in_i : snk_phy_data_in_i};
   assign {src_clk_f, src_full_n_f, src_rd_n_f, src_sel_n_f,
           snk_clk_f, snk_gate_f, snk_soc_f, snk_data_f} = filt;
   // A change counts only once stages two and three agree
   assign next_filt = (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
   assign src_edge = src_clk_f && !src_clk_q;
   assign snk_edge = snk_clk_f && !snk_clk_q;

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt <= '0;
         src_clk_q <= 1'b0;
         snk_clk_q <= 1'b0;
      end
      else
      begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
         src_clk_q <= src_clk_f;
         snk_clk_q <= snk_clk_f;
      end
   end

   // ----------------------------------------
   // Source cell buffer fill
   // ----------------------------------------
   // One cell of storage: a new cell is gathered only after the last one left
   logic [BW-1:0] src_mem [UCP_CELL_BYTES];
   logic [BW-1:0] fifo_data;
   logic fifo_valid, fifo_ready;
   logic src_loaded, next_src_loaded;
   logic [5:0] src_fill_idx, next_src_fill_idx, src_tx_idx, next_src_tx_idx;

   ucp_fifo #(.WIDTH(BW), .DEPTH(FIFO_DEPTH)) u_src_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .in_data_i(src_byte_i),
      .in_valid_i(src_byte_valid_i),
      .in_ready_o(src_byte_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_ready)
   );

   assign fifo_ready = !src_loaded;

   always_ff @(posedge sys_clk_i)
   begin
      if (fifo_valid && fifo_ready)
      begin
         src_mem[src_fill_idx] <= fifo_data;
      end
   end

   // ----------------------------------------
   // Source link engine
   // ----------------------------------------
   logic [1:0] src_stop, next_src_stop;
   logic src_atm_en_n, next_src_atm_en_n, src_send;
   logic [BW-1:0] src_atm_data, next_src_atm_data, src_phy_data, next_src_phy_data;
   logic src_atm_soc, next_src_atm_soc, src_phy_soc, next_src_phy_soc;
   logic src_oe, next_src_oe, src_clav, next_src_clav, src_clav_oe, next_src_clav_oe;
   logic src_sel, next_src_sel, src_rd_n_q, next_src_rd_n_q, src_drive;

   always_comb
   begin
      next_src_loaded = src_loaded;
      next_src_fill_idx = src_fill_idx;
      next_src_tx_idx = src_tx_idx;
      next_src_stop = src_stop;
      next_src_atm_en_n = src_atm_en_n;
      next_src_atm_data = src_atm_data;
      next_src_atm_soc = src_atm_soc;
      next_src_phy_data = src_phy_data;
      next_src_phy_soc = src_phy_soc;
      next_src_oe = src_oe;
      next_src_clav = src_clav;
      next_src_clav_oe = src_clav_oe;
      next_src_sel = src_sel;
      next_src_rd_n_q = src_rd_n_q;
      src_send = 1'b0;
      src_drive = 1'b0;
      if (fifo_valid && fifo_ready)
      begin
         next_src_fill_idx = (src_fill_idx == UCP_IDX_LAST) ? UCP_IDX_FIRST
                             : src_fill_idx + UCP_IDX_STEP;
         next_src_loaded = (src_fill_idx == UCP_IDX_LAST);
      end
      if (src_edge)
      begin
         unique case (src_mode_i)
            UCP_SRC_ATM:
            begin
               // count edges with the PHY full, stop on the third
               next_src_stop = src_full_n_f ? UCP_STOP_CLEAR
                               : (src_stop == UCP_FULL_STOP_EDGES) ? src_stop
                               : src_stop + UCP_STOP_STEP;
               // bytes flow only from a complete buffered cell
               src_send = src_loaded && !(!src_full_n_f && src_stop == UCP_FULL_STOP_EDGES);
               next_src_atm_en_n = !src_send;
            end
            UCP_SRC_SINGLE_PHY_MODE, UCP_SRC_MULTI_PHY_MODE:
            begin
               // selection fixed in single-PHY mode, latched as read enable falls in multi-PHY mode
               if (src_mode_i == UCP_SRC_SINGLE_PHY_MODE)
               begin
                  next_src_sel = 1'b1;
               end
               else if (!src_rd_n_f && src_rd_n_q)
               begin
                  next_src_sel = !src_sel_n_f;
               end
               next_src_rd_n_q = src_rd_n_f;
               // drive only after an enabled, selected cycle
               src_drive = !src_rd_n_f && next_src_sel;
               next_src_oe = src_drive;
               src_send = src_drive && src_loaded;
               // ready follows the buffer one link cycle late
               next_src_clav = src_loaded;
               // polled answer in multi-PHY mode only after our select was low, always driven in single-PHY mode
               next_src_clav_oe = (src_mode_i == UCP_SRC_SINGLE_PHY_MODE) || !src_sel_n_f;
            end
            default:
            begin
               next_src_oe = 1'b0;
               next_src_clav_oe = 1'b0;
            end
         endcase
         if (src_send)
         begin
            next_src_atm_data = src_mem[src_tx_idx];
            next_src_phy_data = src_mem[src_tx_idx];
            next_src_atm_soc = (src_tx_idx == UCP_IDX_FIRST);
            next_src_phy_soc = (src_tx_idx == UCP_IDX_FIRST);
            next_src_tx_idx = (src_tx_idx == UCP_IDX_LAST) ? UCP_IDX_FIRST
                              : src_tx_idx + UCP_IDX_STEP;
            next_src_loaded = (src_tx_idx != UCP_IDX_LAST);
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         src_loaded <= 1'b0;
         src_fill_idx <= UCP_IDX_FIRST;
         src_tx_idx <= UCP_IDX_FIRST;
         src_stop <= UCP_STOP_CLEAR;
         src_atm_en_n <= 1'b1;
         src_atm_data <= '0;
         src_atm_soc <= 1'b0;
         src_phy_data <= '0;
         src_phy_soc <= 1'b0;
         src_oe <= 1'b0;
         src_clav <= 1'b0;
         src_clav_oe <= 1'b0;
         src_sel <= 1'b0;
         src_rd_n_q <= 1'b1;
      end
      else
      begin
         src_loaded <= next_src_loaded;
         src_fill_idx <= next_src_fill_idx;
         src_tx_idx <= next_src_tx_idx;
         src_stop <= next_src_stop;
         src_atm_en_n <= next_src_atm_en_n;
         src_atm_data <= next_src_atm_data;
         src_atm_soc <= next_src_atm_soc;
         src_phy_data <= next_src_phy_data;
         src_phy_soc <= next_src_phy_soc;
         src_oe <= next_src_oe;
         src_clav <= next_src_clav;
         src_clav_oe <= next_src_clav_oe;
         src_sel <= next_src_sel;
         src_rd_n_q <= next_src_rd_n_q;
      end
   end

   assign src_atm_data_out_o = src_atm_data;
   assign src_atm_cell_start_o = src_atm_soc;
   assign src_atm_write_enable_n_o = src_atm_en_n;
   assign src_phy_data_out_o = src_phy_data;
   assign src_phy_cell_start_o = src_phy_soc;
   assign src_phy_data_oe_o = src_oe;
   assign src_phy_cell_ready_o = src_clav;
   assign src_phy_cell_ready_oe_o = src_clav_oe;

   // ----------------------------------------
   // Sink link engine and drain
   // ----------------------------------------
   // Single cell store: space reopens only when the user has drained it
   logic [BW-1:0] snk_mem [UCP_CELL_BYTES];
   logic [5:0] snk_cnt, next_snk_cnt, snk_widx, snk_drain, next_snk_drain;
   logic snk_full, next_snk_full, snk_take;
   logic snk_en_n, next_snk_en_n, snk_space, next_snk_space;

   always_comb
   begin
      next_snk_cnt = snk_cnt;
      next_snk_full = snk_full;
      next_snk_drain = snk_drain;
      next_snk_en_n = snk_en_n;
      next_snk_space = snk_space;
      // ATM byte valid when enabled last cycle and PHY not empty
      // PHY byte on every enabled edge while the store is not full
      snk_take = snk_edge && !snk_full &&
                 ((snk_mode_i == UCP_SNK_ATM) ? (!snk_en_n && snk_gate_f) : !snk_gate_f);
      snk_widx = snk_soc_f ? UCP_IDX_FIRST : snk_cnt;
      if (snk_take)
      begin
         next_snk_full = (snk_widx == UCP_IDX_LAST);
         next_snk_cnt = (snk_widx == UCP_IDX_LAST) ? UCP_IDX_FIRST : snk_widx + UCP_IDX_STEP;
      end
      if (snk_full && snk_byte_ready_i)
      begin
         next_snk_drain = (snk_drain == UCP_IDX_LAST) ? UCP_IDX_FIRST
                          : snk_drain + UCP_IDX_STEP;
         next_snk_full = (snk_drain != UCP_IDX_LAST);
      end
      if (snk_edge)
      begin
         // pulse enable off while the PHY runs dry late in the cell
         if (!snk_en_n && !snk_gate_f && snk_cnt >= UCP_TOGGLE_FROM)
         begin
            next_snk_en_n = 1'b1;
         end
         else
         begin
            // read only while a whole cell fits
            next_snk_en_n = next_snk_full || (snk_mode_i != UCP_SNK_ATM);
         end
         // space offered only below the 49th byte
         next_snk_space = (snk_mode_i == UCP_SNK_SINGLE_PHY_MODE) && !next_snk_full &&
                          (next_snk_cnt < UCP_SPACE_DROP);
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         snk_cnt <= UCP_IDX_FIRST;
         snk_full <= 1'b0;
         snk_drain <= UCP_IDX_FIRST;
         snk_en_n <= 1'b1;
         snk_space <= 1'b0;
      end
      else
      begin
         snk_cnt <= next_snk_cnt;
         snk_full <= next_snk_full;
         snk_drain <= next_snk_drain;
         snk_en_n <= next_snk_en_n;
         snk_space <= next_snk_space;
      end
      if (snk_take)
      begin
         snk_mem[snk_widx] <= snk_data_f;
      end
   end

   assign snk_atm_read_enable_n_o = snk_en_n;
   assign snk_phy_space_ready_o = snk_space;
   assign snk_byte_valid_o = snk_full;
   assign snk_byte_o = snk_mem[snk_drain];
   assign snk_first_o = (snk_drain == UCP_IDX_FIRST);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence full_held_s;
      src_edge && !src_full_n_f && src_stop == UCP_FULL_STOP_EDGES;
   endsequence
   sequence byte49_s;
      snk_take && snk_widx == UCP_SPACE_DROP - UCP_IDX_STEP;
   endsequence
   sequence last_out_s;
      src_edge && src_send && src_tx_idx == UCP_IDX_LAST && src_mode_i != UCP_SRC_ATM;
   endsequence
   sequence idle_edge_s;
      src_edge && !src_loaded && src_mode_i != UCP_SRC_ATM;
   endsequence
   sequence late_dry_s;
      snk_edge && !snk_en_n && !snk_gate_f && snk_cnt >= UCP_TOGGLE_FROM;
   endsequence

   atm_start_a: assert property ($fell(src_atm_write_enable_n_o) |-> $past(src_loaded))
      else $error("ATM source enabled without a full cell");
   full_stop_a: assert property (full_held_s |=> src_atm_write_enable_n_o [*2])
      else $error("ATM source kept enable after full");
   cell_ready_a: assert property ($rose(src_phy_cell_ready_o) |-> src_loaded)
      else $error("cell ready raised without a cell");
   phy_float_a: assert property ($rose(src_phy_data_oe_o) |-> !$past(src_rd_n_f))
      else $error("source drove data without read enable");
   cell_done_a: assert property (last_out_s |=> !src_loaded)
      else $error("cell still held after its last byte");
   ready_drop_a: assert property (idle_edge_s |=> !src_phy_cell_ready_o)
      else $error("cell ready did not drop after last byte");
   clav_drive_a: assert property ($rose(src_phy_cell_ready_oe_o)
      && src_mode_i == UCP_SRC_MULTI_PHY_MODE |-> !$past(src_sel_n_f))
      else $error("cell ready driven while not polled");
   multi_phy_mode_sel_a: assert property (src_phy_data_oe_o
      && src_mode_i == UCP_SRC_MULTI_PHY_MODE |-> src_sel)
      else $error("multi-PHY data driven while unselected");
   soc_first_a: assert property ($rose(src_atm_cell_start_o) |-> src_tx_idx == UCP_IDX_STEP)
      else $error("start of cell not on first byte");
   snk_enable_a: assert property ($fell(snk_atm_read_enable_n_o) |-> !snk_full)
      else $error("sink enabled without room for a cell");
   space_gate_a: assert property (snk_phy_space_ready_o
      |-> !snk_full && snk_cnt < UCP_SPACE_DROP)
      else $error("space offered without room");
   drop_49_a: assert property (byte49_s |=> !snk_phy_space_ready_o)
      else $error("space not withdrawn at byte 49");
   dry_toggle_a: assert property (late_dry_s |=> snk_atm_read_enable_n_o)
      else $error("sink kept enable while the PHY ran dry late in a cell");
endmodule

// *** hw/ucp_pkg.sv ***
// Shared constants and mode types for the cell port pair
package ucp_pkg;

   // ----------------------------------------
   // Cell framing
   // ----------------------------------------
   localparam int UCP_CELL_BYTES = 53;
   localparam int UCP_BYTE_W = 8;
   localparam logic [5:0] UCP_IDX_FIRST = 6'h00;
   localparam logic [5:0] UCP_IDX_STEP = 6'h01;
   localparam logic [5:0] UCP_IDX_LAST = 6'h34;
   // Sink stops offering space once this many bytes of the cell are in
   localparam logic [5:0] UCP_SPACE_DROP = 6'h31;
   // Bytes received before byte 51 arrives
   localparam logic [5:0] UCP_TOGGLE_FROM = 6'h32;

   // ----------------------------------------
   // Link handshake timing, in link clock edges
   // ----------------------------------------
   localparam logic [1:0] UCP_FULL_STOP_EDGES = 2'h2;
   localparam logic [1:0] UCP_STOP_STEP = 2'h1;
   localparam logic [1:0] UCP_STOP_CLEAR = 2'h0;

   // ----------------------------------------
   // Buffering
   // ----------------------------------------
   localparam int UCP_FIFO_DEPTH = 8;

   // ----------------------------------------
   // Port roles
   // ----------------------------------------
   typedef enum logic [1:0] {UCP_SRC_ATM, UCP_SRC_SINGLE_PHY_MODE, UCP_SRC_MULTI_PHY_MODE} ucp_src_mode_t;
   typedef enum logic {UCP_SNK_ATM, UCP_SNK_SINGLE_PHY_MODE} ucp_snk_mode_t;

endpackage

// *** verif/ucp_cell_port_pair_tb.sv ***
// Random self-checking bench for the cell port pair and its link partner
`timescale 1ns/1ps

module ucp_cell_port_pair_tb;
   import ucp_pkg::*;

   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic lk = 1'b0;
   ucp_src_mode_t src_mode_i = UCP_SRC_ATM;
   ucp_snk_mode_t snk_mode_i = UCP_SNK_ATM;
   logic [7:0] src_byte_i = 8'h00;
   logic [7:0] snk_phy_data_in_i = 8'h00;
   logic [7:0] snk_byte_o, src_atm_data_out_o, src_phy_data_out_o, snk_atm_data_in_i;
   logic src_byte_valid_i = 1'b0;
   logic snk_byte_ready_i = 1'b0;
   logic src_phy_read_enable_n_i = 1'b1;
   logic src_phy_port_select_n_i = 1'b1;
   logic snk_phy_cell_start_i = 1'b0;
   logic snk_phy_write_enable_n_i = 1'b1;
   logic src_byte_ready_o, snk_first_o, snk_byte_valid_o, src_atm_phy_full_n_i;
   logic src_atm_cell_start_o, src_atm_write_enable_n_o, src_phy_cell_start_o;
   logic src_phy_data_oe_o, src_phy_cell_ready_o, src_phy_cell_ready_oe_o;
   logic snk_atm_cell_start_i, snk_atm_phy_empty_n_i, snk_atm_read_enable_n_o;
   logic snk_phy_space_ready_o;
   logic took = 1'b0;
   logic [1:0] stall = 2'h0;
   logic [31:0] seed = 32'h00017777;
   logic [7:0] sent[$];
   int failures = 0, tests_run = 0, rcell = 0, ridx = 0, scnt = 0, wc = 0, lim = 1000000;
   int pm_bad;

   ucp_cell_port_pair dut_u
   (
      .sys_clk_i, .rst_i, .src_mode_i, .snk_mode_i, .src_byte_i, .src_byte_valid_i,
      .src_byte_ready_o, .snk_byte_o, .snk_first_o, .snk_byte_valid_o, .snk_byte_ready_i,
      .src_atm_if_clk_i(lk), .src_atm_phy_full_n_i, .src_atm_data_out_o,
      .src_atm_cell_start_o, .src_atm_write_enable_n_o, .src_phy_if_clk_i(lk),
      .src_phy_read_enable_n_i, .src_phy_port_select_n_i, .src_phy_data_out_o,
      .src_phy_cell_start_o, .src_phy_data_oe_o, .src_phy_cell_ready_o,
      .src_phy_cell_ready_oe_o, .snk_atm_if_clk_i(lk), .snk_atm_data_in_i,
      .snk_atm_cell_start_i, .snk_atm_phy_empty_n_i, .snk_atm_read_enable_n_o,
      .snk_phy_if_clk_i(lk), .snk_phy_data_in_i, .snk_phy_cell_start_i,
      .snk_phy_write_enable_n_i, .snk_phy_space_ready_o
   );

   ucp_phy_model pm_u
   (
      .sys_clk_i, .rst_i, .lk_i(lk), .stall_i(stall), .tx_data_i(src_atm_data_out_o),
      .tx_start_i(src_atm_cell_start_o), .tx_en_n_i(src_atm_write_enable_n_o),
      .tx_full_n_o(src_atm_phy_full_n_i), .rx_en_n_i(snk_atm_read_enable_n_o),
      .rx_data_o(snk_atm_data_in_i), .rx_start_o(snk_atm_cell_start_i),
      .rx_empty_n_o(snk_atm_phy_empty_n_i), .bad_o(pm_bad)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [7:0] cell_byte(input int c, input int i);
      return 8'(c * 29 + i * 3);
   endfunction

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_flag(input string what, input logic exp, input logic got);
      check_byte(what, {7'h00, exp}, {7'h00, got});
   endtask

   task automatic give_verdict();
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Inputs move just after the link falling edge, on a system falling edge
   task automatic lk_step();
      @(negedge lk);
      @(negedge sys_clk_i);
   endtask

   task automatic restart(input ucp_src_mode_t sm, input ucp_snk_mode_t km);
      lk_step();
      rst_i <= 1'b1;
      src_mode_i <= sm;
      snk_mode_i <= km;
      sent.delete();
      {rcell, ridx, scnt, wc} = '0;
      repeat (6) @(negedge sys_clk_i);
      rst_i <= 1'b0;
   endtask

   // Byte k shows one link edge after the edge that saw the enable for it
   task automatic src_cell();
      // read only once a cell is offered
      repeat (300) if (src_phy_cell_ready_o !== 1'b1) @(posedge lk);
      lk_step();
      src_phy_read_enable_n_i = 1'b0;
      @(posedge lk);
      for (int i = 0; i <= 53; i++)
      begin
         @(posedge lk);
         if (i <= 52)
            check_byte("phy byte", sent[scnt], src_phy_data_out_o);
         if (i <= 52)
            check_flag("phy start", i == 0, src_phy_cell_start_o);
         scnt += i <= 52;
         check_flag("phy drive", i <= 52, src_phy_data_oe_o);
         check_flag("phy ready", i <= 52, src_phy_cell_ready_o);
         if (i == 51)
         begin
            lk_step();
            src_phy_read_enable_n_i = 1'b1;
         end
      end
   endtask

   task automatic snk_cell();
      // write only once space is offered
      repeat (300) if (snk_phy_space_ready_o !== 1'b1) @(posedge lk);
      for (int i = 0; i <= 53; i++)
      begin
         lk_step();
         snk_phy_write_enable_n_i = i == 53;
         snk_phy_data_in_i = cell_byte(wc, i);
         snk_phy_cell_start_i = i == 0;
         @(posedge lk);
         check_flag("space ready", i < 49, snk_phy_space_ready_o);
      end
      wc++;
   endtask

   // ----------------------------------------
   // Clocks, feeders and the drain checker
   // ----------------------------------------
   initial
      forever #50 sys_clk_i = ~sys_clk_i;

   initial
   begin
      #230;
      forever #400 lk = ~lk;
   end

   always @(negedge lk)
   begin
      seed = xs(seed);
      stall <= {seed[3] & seed[4], seed[5] & seed[6]};
   end

   always @(negedge sys_clk_i)
   begin
      seed = xs(seed);
      if (took)
         src_byte_i <= seed[7:0];
      src_byte_valid_i <= !rst_i && sent.size() < lim;
      snk_byte_ready_i <= seed[9] | seed[10];
   end

   always @(posedge sys_clk_i)
   begin
      took <= src_byte_valid_i && src_byte_ready_o === 1'b1 && !rst_i;
      if (src_byte_valid_i && src_byte_ready_o === 1'b1 && !rst_i)
         sent.push_back(src_byte_i);
      if (!rst_i && snk_byte_valid_o === 1'b1 && snk_byte_ready_i)
      begin
         check_byte("sink byte", cell_byte(rcell, ridx), snk_byte_o);
         check_flag("sink first", ridx == 0, snk_first_o);
         ridx = (ridx + 1) % UCP_CELL_BYTES;
         rcell += ridx == 0;
      end
   end

   // Cut short a hang
   initial
   begin
      #2000000;
      failures++;
      give_verdict();
   end

   initial
   begin
      restart(UCP_SRC_ATM, UCP_SNK_ATM);
      repeat (10000) if (pm_u.got.size() < 212 || rcell < 4) @(posedge sys_clk_i);
      foreach (pm_u.got[k])
         check_byte("atm source byte", sent[k], pm_u.got[k]);
      check_flag("atm source cells", 1'b1, pm_u.got.size() >= 212);
      check_byte("partner faults", 8'h00, 8'(pm_bad));
      check_flag("atm sink cells", 1'b1, rcell >= 4);
      lim = 52;
      restart(UCP_SRC_SINGLE_PHY_MODE, UCP_SNK_SINGLE_PHY_MODE);
      repeat (12) @(posedge lk);
      check_flag("cell ready early", 1'b0, src_phy_cell_ready_o);
      check_flag("drive while idle", 1'b0, src_phy_data_oe_o);
      lim = 200;
      fork
         repeat (2) src_cell();
         repeat (2) snk_cell();
      join
      repeat (300) @(posedge sys_clk_i);
      check_byte("phy sink cells", 8'h02, 8'(rcell));
      restart(UCP_SRC_MULTI_PHY_MODE, UCP_SNK_SINGLE_PHY_MODE);
      repeat (12) @(posedge lk);
      lk_step();
      src_phy_read_enable_n_i = 1'b0;
      repeat (2) @(posedge lk);
      check_flag("multi_phy_mode ready drive", 1'b0, src_phy_cell_ready_oe_o);
      check_flag("multi_phy_mode data drive", 1'b0, src_phy_data_oe_o);
      lk_step();
      src_phy_port_select_n_i = 1'b0;
      repeat (2) @(posedge lk);
      check_flag("multi_phy_mode ready drive", 1'b1, src_phy_cell_ready_oe_o);
      check_flag("multi_phy_mode ready value", 1'b1, src_phy_cell_ready_o);
      check_flag("multi_phy_mode late select", 1'b0, src_phy_data_oe_o);
      lk_step();
      src_phy_read_enable_n_i = 1'b1;
      lk_step();
      src_phy_read_enable_n_i = 1'b0;
      repeat (2) @(posedge lk);
      check_flag("multi_phy_mode data drive", 1'b1, src_phy_data_oe_o);
      check_byte("multi_phy_mode first byte", sent[0], src_phy_data_out_o);
      check_flag("multi_phy_mode first start", 1'b1, src_phy_cell_start_o);
      give_verdict();
   end
endmodule

// *** verif/ucp_phy_model.sv ***
// Cell FIFO stand-in facing the two ATM-role link ports
`timescale 1ns/1ps

module ucp_phy_model
(
   // Clocks, reset and stalls
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic lk_i,
   input wire logic [1:0] stall_i,
   // Source port writes cells in
   input wire logic [7:0] tx_data_i,
   input wire logic tx_start_i,
   input wire logic tx_en_n_i,
   output logic tx_full_n_o,
   // Sink port reads cells out
   input wire logic rx_en_n_i,
   output logic [7:0] rx_data_o,
   output logic rx_start_o,
   output logic rx_empty_n_o,
   // Fault count
   output int bad_o
);
   logic [7:0] got[$];
   logic [2:0] full_seen;
   logic taken;
   int tidx, ridx, rcell;

   initial
   begin
      {tx_full_n_o, rx_data_o, rx_start_o, rx_empty_n_o} = 11'h400;
      bad_o = 0;
   end

   always @(posedge sys_clk_i)
      if (rst_i)
      begin
         got.delete();
         full_seen = 3'h7;
         taken = 1'b0;
         {tidx, ridx, rcell} = '0;
      end

   // ----------------------------------------
   // Link edge sampling
   // ----------------------------------------
   always @(posedge lk_i)
   begin
      // enable released after full stays low
      if (full_seen == 3'h0 && tx_en_n_i !== 1'b1)
         bad_o++;
      full_seen = {full_seen[1:0], tx_full_n_o};
      // one byte per enabled edge, start on byte 0
      if (tx_en_n_i === 1'b0)
      begin
         if (tx_start_i !== (tidx % 53 == 0))
            bad_o++;
         got.push_back(tx_data_i);
         tidx++;
      end
      taken = rx_en_n_i === 1'b0 && rx_empty_n_o;
   end

   // sink data moves one edge after a taken byte
   always @(negedge lk_i)
   begin
      @(negedge sys_clk_i);
      if (taken)
      begin
         ridx = (ridx + 1) % 53;
         rcell += ridx == 0;
      end
      rx_empty_n_o <= !stall_i[1];
      rx_data_o <= 8'(rcell * 29 + ridx * 3);
      rx_start_o <= ridx == 0;
      tx_full_n_o <= !stall_i[0];
   end
endmodule
